/* File: verilog/spcs_pkg.sv */
// Constants and carrier types of the serial port control and status block
package spcs_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets on APB
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_DATA = 8'h00, OFS_STATUS = 8'h04, OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_FORMAT = 8'h0C, OFS_BAUDH = 8'h10, OFS_BAUDL = 8'h14;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  // serial_status_control
  localparam int B_RXC = 7, B_TXC = 6, B_BUFFER_EMPTY_FLAG = 5, B_FE = 4;
  localparam int B_DOR = 3, B_UPE = 2, B_DSPD = 1, B_AFM = 0;
  // serial_irq_enable_control
  localparam int B_RXIE = 7, B_TXIE = 6, B_BEIE = 5, B_RXON = 4;
  localparam int B_TXON = 3, B_CSZM = 2, B_RECEIVED_NINTH_BIT = 1, B_TRANSMIT_NINTH_BIT = 0;
  // serial_frame_format
  localparam int B_SYNC = 6, B_PAR = 4, B_STOP = 3, B_CSZL = 1, B_CPOL = 0;
  // baud_divisor_high
  localparam int B_BAUDH = 0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_STATUS = 8'h20, RST_CTRL = 8'h00, RST_FORMAT = 8'h06;
  localparam logic [7:0] RST_BAUDH = 8'h00, RST_BAUDL = 8'h00;

  // ---------------------------------------------------------------------------
  // Encodings and ratios
  // ---------------------------------------------------------------------------
  localparam logic [2:0] CSZ_9 = 3'h7;
  localparam logic [4:0] OVS_NORMAL = 5'h10, OVS_DOUBLE = 5'h08, OVS_SYNC = 5'h02;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} spcs_rx_st_t;

  // One received character with its error marks
  typedef struct packed {
    logic       fe;
    logic       pe;
    logic [8:0] data;
  } spcs_rx_ent_t;

  // Complete state of the block
  typedef struct packed {
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic                    rx_ie;
    logic                    tx_ie;
    logic                    be_ie;
    logic                    rx_on;
    logic                    tx_on_req;
    logic                    csz_msb;
    logic                    tx_b8;
    logic                    sync;
    logic [1:0]              par;
    logic                    stop2;
    logic [1:0]              csz_low;
    logic                    cpol;
    logic                    dspd;
    logic                    afm;
    logic [11:0]             baud;
    logic [11:0]             presc;
    logic                    tick;
    logic [8:0]              tx_buf;
    logic                    tx_full;
    logic                    tx_busy;
    logic [12:0]             tx_sr;
    logic [3:0]              tx_left;
    logic [4:0]              tx_ph;
    logic                    transmit_done_flag;
    logic                    tx_pin;
    logic                    txd;
    logic                    txd_oe_n;
    logic                    transfer_clock_pin;
    logic                    xck_oe_n;
    spcs_rx_st_t             rx_st;
    logic [4:0]              rx_ph;
    logic [3:0]              rx_cnt;
    logic [8:0]              rx_sr;
    logic                    rx_pbit;
    logic                    rx_drop;
    spcs_rx_ent_t [1:0]      rx_mem;
    logic [1:0]              rx_fill;
    logic                    rx_rd;
    spcs_rx_ent_t            rx_hold;
    logic                    rx_hold_v;
    logic                    overrun_flag;
    logic                    irq_rx;
    logic                    irq_txc;
    logic                    irq_be;
  } spcs_state_t;

endpackage

/* File: verilog/spcs_top.sv */
// Serial port control, status, frame and baud logic behind an APB slave
// Functional notes
// - Transmit-done sets when the frame has left and no character is buffered.
// - Transmit-done clears on interrupt acknowledge or a written one.
// - Buffer-empty reads one while the transmit buffer can take data; set at reset.
// - Frame error reports a zero first stop bit of the next unread character.
// - Overrun flags when buffer full, a character waits, and a start arrives.
// - Parity error reports a mismatch of the next unread character when checking.
// - Double speed cuts the divider from 16 to 8, asynchronous mode only.
// - Address filtering discards data frames; transmitter unaffected.
// - Each interrupt needs its enable, the global enable and its flag.
// - Receiver on owns the pin; off flushes buffer and error flags.
// - Transmitter owns its pin; disable waits until shifter and buffer empty.
// - Mode select zero is asynchronous, one synchronous.
// - Parity field: off, reserved, even, odd; generate and check when enabled.
// - Stop select gives one or two transmitted stop bits; receiver ignores it.
// - Character size codes give 5 to 8 bits or 9 bits.
// - Clock polarity picks the transfer clock edges for change and sample.
// - Divisor is 12 bits; a low byte write reloads the prescaler at once.
// - Receive-complete shows that unread characters remain in the buffer.
// - Data writes while the buffer is not empty are ignored.
// - Receive buffer is a two-entry queue advanced by data reads.
// - Frame-type bit is the first stop bit, or the ninth bit for 9-bit frames.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module spcs_top (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // APB slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  // Processor interrupt context
  input  wire logic       cpu_global_irq_enable,
  input  wire logic       txc_irq_ack,
  output logic            receive_irq,
  output logic            transmit_done_irq,
  output logic            buffer_empty_irq,
  // Serial pins
  input  wire logic       rxd_in,
  output logic            rxd_owned,
  output logic            txd_out,
  output logic            txd_oe_n,
  output logic            transfer_clock_pin_out,
  output logic            transfer_clock_pin_oe_n
);

  // ---------------------------------------------------------------------------
  // State and decode
  // ---------------------------------------------------------------------------
  spcs_pkg::spcs_state_t  s;
  spcs_pkg::spcs_state_t  n;
  spcs_pkg::spcs_rx_ent_t head;
  spcs_pkg::spcs_rx_ent_t ent;
  logic                   acc;
  logic                   wr;
  logic                   rd_data;
  logic                   wr_data;
  logic                   wr_baudl;
  logic [2:0]             csz;
  logic [3:0]             nbits;
  logic [4:0]             ovs;
  logic                   par_en;
  logic [12:0]            txf;
  logic [3:0]             txlen;
  logic                   pbit;
  logic                   ftype;
  logic                   receive_complete_flag;
  logic [4:0]             rx_lim;
  logic                   idx;
  logic [31:0]            rdmux;
  logic                   mapped;

  // Access completes in the cycle pready is shown
  assign acc      = psel & penable & s.pready;
  assign wr       = acc & pwrite;
  assign wr_data  = wr & (paddr == spcs_pkg::OFS_DATA);
  assign wr_baudl = wr & (paddr == spcs_pkg::OFS_BAUDL);
  assign rd_data  = acc & ~pwrite & (paddr == spcs_pkg::OFS_DATA);

  // Character size decode
  // Reserved codes fall back to eight bits rather than stall the link
  assign csz    = {s.csz_msb, s.csz_low};
  assign nbits  = (csz == spcs_pkg::CSZ_9) ? 4'h9 :
                  (csz[2] ? 4'h8 : (4'h5 + {2'b00, csz[1:0]}));
  // Ticks per bit; double speed only in asynchronous mode
  assign ovs    = s.sync ? spcs_pkg::OVS_SYNC :
                  (s.dspd ? spcs_pkg::OVS_DOUBLE : spcs_pkg::OVS_NORMAL);
  // Parity enabled by the upper field bit
  assign par_en = s.par[1];
  assign txlen  = 4'h1 + nbits + {3'b000, par_en} + (s.stop2 ? 4'h2 : 4'h1);
  assign receive_complete_flag    = (s.rx_fill != 2'b00);
  assign head   = s.rx_mem[s.rx_rd];
  // Start state samples mid-bit, later states one bit apart
  assign rx_lim = (s.rx_st == spcs_pkg::RX_START) ? ({1'b0, ovs[4:1]} - 5'h01)
                                                  : (ovs - 5'h01);

  // ---------------------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------------------
  // Error flags show only while a character is present
  always_comb begin
    mapped = 1'b1;
    case (paddr)
      spcs_pkg::OFS_DATA:   rdmux = {24'h000000, receive_complete_flag ? head.data[7:0] : 8'h00};
      // Status view of the head character
      spcs_pkg::OFS_STATUS: rdmux = {24'h000000, receive_complete_flag, s.transmit_done_flag, ~s.tx_full, head.fe & receive_complete_flag,
                                     s.overrun_flag, head.pe & receive_complete_flag, s.dspd, s.afm};
      spcs_pkg::OFS_CTRL:   rdmux = {24'h000000, s.rx_ie, s.tx_ie, s.be_ie, s.rx_on,
                                     s.tx_on_req, s.csz_msb, head.data[8] & receive_complete_flag, s.tx_b8};
      spcs_pkg::OFS_FORMAT: rdmux = {24'h000000, 1'b0, s.sync, s.par, s.stop2,
                                     s.csz_low, s.cpol};
      spcs_pkg::OFS_BAUDH:  rdmux = {24'h000000, 4'h0, s.baud[11:8]};
      spcs_pkg::OFS_BAUDL:  rdmux = {24'h000000, s.baud[7:0]};
      default: begin
        rdmux  = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    n     = s;
    txf   = '1;
    pbit  = 1'b0;
    ent   = '0;
    ftype = 1'b0;
    idx   = 1'b0;
    // Zero-wait answer: ready in every access phase
    n.pready  = psel & ~penable;
    n.pslverr = psel & ~penable & ~mapped;
    if (psel && !penable) begin
      n.prdata = rdmux;
    end
    if (txc_irq_ack) begin
      n.transmit_done_flag = 1'b0;
    end
    // Register writes; error flag positions of status are not writable
    if (wr) begin
      case (paddr)
        spcs_pkg::OFS_STATUS: begin
          if (pwdata[spcs_pkg::B_TXC]) begin
            n.transmit_done_flag = 1'b0;
          end
          n.dspd = pwdata[spcs_pkg::B_DSPD];
          n.afm  = pwdata[spcs_pkg::B_AFM];
        end
        spcs_pkg::OFS_CTRL: begin
          n.rx_ie     = pwdata[spcs_pkg::B_RXIE];
          n.tx_ie     = pwdata[spcs_pkg::B_TXIE];
          n.be_ie     = pwdata[spcs_pkg::B_BEIE];
          n.rx_on     = pwdata[spcs_pkg::B_RXON];
          n.tx_on_req = pwdata[spcs_pkg::B_TXON];
          n.csz_msb   = pwdata[spcs_pkg::B_CSZM];
          n.tx_b8     = pwdata[spcs_pkg::B_TRANSMIT_NINTH_BIT];
        end
        spcs_pkg::OFS_FORMAT: begin
          n.sync    = pwdata[spcs_pkg::B_SYNC];
          n.par     = pwdata[spcs_pkg::B_PAR +: 2];
          n.stop2   = pwdata[spcs_pkg::B_STOP];
          n.csz_low = pwdata[spcs_pkg::B_CSZL +: 2];
          n.cpol    = pwdata[spcs_pkg::B_CPOL];
        end
        spcs_pkg::OFS_BAUDH: n.baud[11:8] = pwdata[spcs_pkg::B_BAUDH +: 4];
        spcs_pkg::OFS_BAUDL: n.baud[7:0] = pwdata[7:0];
        default: n.baud = s.baud;
      endcase
    end
    // Prescaler: period of divisor plus one, reloaded by low write
    if (wr_baudl) begin
      n.presc = {s.baud[11:8], pwdata[7:0]};
      n.tick  = 1'b0;
    end else if (s.presc == 12'h000) begin
      n.presc = s.baud;
      n.tick  = 1'b1;
    end else begin
      n.presc = s.presc - 12'h001;
      n.tick  = 1'b0;
    end
    // Buffer takes a character only when empty; ninth bit was set before
    if (wr_data && !s.tx_full) begin
      n.tx_buf  = {s.tx_b8, pwdata[7:0]};
      n.tx_full = 1'b1;
    end
    // Frame image: start, data, parity, then ones for stop bits
    for (int i = 0; i < 9; i++) begin
      if (i < nbits) begin
        txf[i + 1] = s.tx_buf[i];
        pbit       = pbit ^ s.tx_buf[i];
      end
    end
    txf[0] = 1'b0;
    if (par_en) begin
      txf[nbits + 4'h1] = pbit ^ s.par[0];
    end
    // Load only while the transmitter still owns its pin
    if (s.tx_pin && !s.tx_busy && s.tx_full) begin
      n.txd     = txf[0];
      n.tx_sr   = {1'b1, txf[12:1]};
      n.tx_left = txlen - 4'h1;
      n.tx_ph   = 5'h00;
      n.tx_busy = 1'b1;
      n.tx_full = 1'b0;
    end else if (s.tx_busy && s.tick) begin
      if (s.tx_ph == ovs - 5'h01) begin
        n.tx_ph = 5'h00;
        if (s.tx_left == 4'h0) begin
          n.tx_busy = 1'b0;
          n.txd     = 1'b1;
          // Done only when nothing waits behind this frame
          if (!s.tx_full) begin
            n.transmit_done_flag = 1'b1;
          end
        end else begin
          n.txd     = s.tx_sr[0];
          n.tx_sr   = {1'b1, s.tx_sr[12:1]};
          n.tx_left = s.tx_left - 4'h1;
        end
      end else begin
        n.tx_ph = s.tx_ph + 5'h01;
      end
    end
    // Pin held until pending and ongoing frames are out
    n.tx_pin   = s.tx_on_req | (s.tx_pin & (s.tx_busy | s.tx_full));
    n.txd_oe_n = ~n.tx_pin;
    // Transfer clock leads each bit with the data-change edge
    n.transfer_clock_pin      = (s.sync && n.tx_busy) ? ((n.tx_ph == 5'h00) ^ s.cpol) : s.cpol;
    n.xck_oe_n = ~(s.sync & n.tx_pin);
    // A data read pops the head; the overrun mark goes with it
    if (rd_data && receive_complete_flag) begin
      n.rx_rd   = ~s.rx_rd;
      n.rx_fill = s.rx_fill - 2'b01;
      n.overrun_flag     = 1'b0;
    end
    // Waiting shift-register character moves up once room appears
    if (s.rx_hold_v && n.rx_fill != 2'b10) begin
      idx             = n.rx_rd ^ n.rx_fill[0];
      n.rx_mem[idx]   = s.rx_hold;
      n.rx_fill       = n.rx_fill + 2'b01;
      n.rx_hold_v     = 1'b0;
    end
    // Receiver sequencer
    case (s.rx_st)
      spcs_pkg::RX_IDLE: begin
        if (!rxd_in) begin
          n.rx_st   = spcs_pkg::RX_START;
          n.rx_ph   = 5'h00;
          n.rx_cnt  = 4'h0;
          n.rx_sr   = 9'h000;
          // Start bit with no place left for this frame
          n.rx_drop = (s.rx_fill == 2'b10) & s.rx_hold_v;
          if ((s.rx_fill == 2'b10) && s.rx_hold_v) begin
            n.overrun_flag = 1'b1;
          end
        end
      end
      default: begin
        if (s.tick) begin
          n.rx_ph = (s.rx_ph == rx_lim) ? 5'h00 : (s.rx_ph + 5'h01);
        end
        if (s.tick && s.rx_ph == rx_lim) begin
          case (s.rx_st)
            // False start: line back high at mid-bit
            spcs_pkg::RX_START: n.rx_st = rxd_in ? spcs_pkg::RX_IDLE : spcs_pkg::RX_DATA;
            spcs_pkg::RX_DATA: begin
              n.rx_sr[s.rx_cnt] = rxd_in;
              n.rx_cnt          = s.rx_cnt + 4'h1;
              if (s.rx_cnt == nbits - 4'h1) begin
                n.rx_st = par_en ? spcs_pkg::RX_PAR : spcs_pkg::RX_STOP;
              end
            end
            spcs_pkg::RX_PAR: begin
              n.rx_pbit = rxd_in;
              n.rx_st   = spcs_pkg::RX_STOP;
            end
            default: begin
              // Only the first stop bit is looked at
              n.rx_st  = spcs_pkg::RX_IDLE;
              // Frame error from a low first stop bit
              ent.fe   = ~rxd_in;
              // Mismatch against even or odd, only with checking on
              ent.pe   = par_en & ((^s.rx_sr ^ s.rx_pbit) != s.par[0]);
              ent.data = s.rx_sr;
              // Frame type from ninth bit or first stop bit
              ftype    = (csz == spcs_pkg::CSZ_9) ? s.rx_sr[8] : rxd_in;
              // Data frames dropped while address filtering
              if (!s.rx_drop && !(s.afm && !ftype)) begin
                if (n.rx_fill != 2'b10) begin
                  idx           = n.rx_rd ^ n.rx_fill[0];
                  n.rx_mem[idx] = ent;
                  n.rx_fill     = n.rx_fill + 2'b01;
                end else begin
                  n.rx_hold   = ent;
                  n.rx_hold_v = 1'b1;
                end
              end
            end
          endcase
        end
      end
    endcase
    // Receiver off flushes the queue and its error marks
    if (!s.rx_on) begin
      n.rx_st     = spcs_pkg::RX_IDLE;
      n.rx_fill   = 2'b00;
      n.rx_hold_v = 1'b0;
      n.overrun_flag       = 1'b0;
    end
    // Requests need own enable, global enable and flag
    n.irq_rx  = n.rx_ie & cpu_global_irq_enable & (n.rx_fill != 2'b00);
    n.irq_txc = n.tx_ie & cpu_global_irq_enable & n.transmit_done_flag;
    n.irq_be  = n.be_ie & cpu_global_irq_enable & ~n.tx_full;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Package constants and idle-high txd and output enables under reset; the rest of the reset image is zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s            <= '0;
      s.tx_full    <= ~spcs_pkg::RST_STATUS[spcs_pkg::B_BUFFER_EMPTY_FLAG];
      s.rx_ie      <= spcs_pkg::RST_CTRL[spcs_pkg::B_RXIE];
      s.csz_low    <= spcs_pkg::RST_FORMAT[spcs_pkg::B_CSZL +: 2];
      s.baud       <= {spcs_pkg::RST_BAUDH[3:0], spcs_pkg::RST_BAUDL};
      s.txd        <= 1'b1;
      s.txd_oe_n   <= 1'b1;
      s.xck_oe_n   <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign prdata                  = s.prdata;
  assign pready                  = s.pready;
  assign pslverr                 = s.pslverr;
  assign receive_irq             = s.irq_rx;
  assign transmit_done_irq       = s.irq_txc;
  assign buffer_empty_irq        = s.irq_be;
  // Receive pin taken over while the receiver is on
  assign rxd_owned               = s.rx_on;
  assign txd_out                 = s.txd;
  assign txd_oe_n                = s.txd_oe_n;
  assign transfer_clock_pin_out  = s.transfer_clock_pin;
  assign transfer_clock_pin_oe_n = s.xck_oe_n;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence tx_drain_s;
    !s.tx_on_req && s.tx_pin && (s.tx_busy || s.tx_full);
  endsequence
  sequence tx_off_s;
    !s.tx_on_req && !s.tx_busy && !s.tx_full;
  endsequence
  sequence presc_quiet_s;
    (s.tick && s.presc == 12'h003 && !wr_baudl) ##1 (!wr_baudl) [*3];
  endsequence

  chk_txc_frame_end: assert property (
    $fell(s.tx_busy) && !s.tx_full |-> s.transmit_done_flag)
    else $error("transmit done not set at frame end");
  chk_txc_ack_clear: assert property (
    s.transmit_done_flag && txc_irq_ack && !s.tx_busy |=> !s.transmit_done_flag)
    else $error("transmit done not cleared by acknowledge");
  chk_buf_take_write: assert property (
    wr_data && !s.tx_full |=> s.tx_full && s.tx_buf[7:0] == $past(pwdata[7:0]))
    else $error("empty buffer did not take the write");
  chk_buf_full_ignore: assert property (
    wr_data && s.tx_full && !(s.tx_pin && !s.tx_busy) |=> $stable(s.tx_buf))
    else $error("write to full buffer was not ignored");
  chk_overrun_set: assert property (
    s.rx_on && s.rx_st == spcs_pkg::RX_IDLE && !rxd_in && s.rx_fill == 2'b10
    && s.rx_hold_v |=> s.overrun_flag)
    else $error("overrun not flagged");
  chk_rx_flush_off: assert property (
    !s.rx_on |=> s.rx_fill == 2'b00 && !s.overrun_flag && !s.rx_hold_v)
    else $error("receiver off did not flush");
  chk_tx_pin_held: assert property (
    tx_drain_s |=> s.tx_pin && !s.txd_oe_n)
    else $error("transmit pin released too early");
  chk_tx_pin_free: assert property (
    tx_off_s |=> !s.tx_pin ##0 s.txd_oe_n)
    else $error("transmit pin not released");
  chk_be_irq_gate: assert property (
    ##1 s.irq_be == (s.be_ie && !s.tx_full && $past(cpu_global_irq_enable)))
    else $error("buffer empty request gating wrong");
  chk_presc_reload: assert property (
    wr_baudl |=> s.presc == s.baud && !s.tick)
    else $error("low divisor write did not reload prescaler");
  chk_tick_period: assert property (
    presc_quiet_s |=> s.tick)
    else $error("tick period not divisor plus one");
  chk_rx_pop_one: assert property (
    rd_data && s.rx_fill == 2'b01 && !s.rx_hold_v && s.rx_st != spcs_pkg::RX_STOP
    |=> s.rx_fill == 2'b00 && s.rx_rd != $past(s.rx_rd))
    else $error("data read did not advance receive queue");

endmodule // spcs_top

/* File: sim/spcs_remote.sv */
// Remote serial transceiver model facing the receive and transmit lines
`timescale 1ns/1ps
module spcs_remote (
  // Clock and bit period in clock cycles
  input  wire logic       pclk,
  input  wire logic [4:0] bit_cyc,
  // Serial lines
  input  wire logic       txd,
  output logic            rxd,
  output logic [7:0]      got
);
  // stop level chosen by caller, so a broken frame can be sent on purpose
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask
  // Capture frames LSB first at mid-bit; line idles high between frames
  initial begin
    rxd = 1'b1;
    got = 8'h00;
    forever begin
      @(negedge txd);
      repeat (bit_cyc / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge pclk);
        got[i] = txd;
      end
    end
  end
endmodule // spcs_remote

/* File: sim/spcs_top_tb.sv */
// Self-checking bench for the serial port control and status block
`timescale 1ns/1ps
module spcs_top_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        glb = 1'b0, ack = 1'b0, pready, pslverr, slv, rxd, rx_irq, txc_irq;
  logic        be_irq, rxd_own, txd, txd_oe_n, transfer_clock_pin, xck_oe_n;
  logic [4:0]  bit_cyc = 5'h10;
  logic [7:0]  paddr = 8'h00, got;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int          n_errors = 0, num_checks = 0, cycles = 0;

  always #25 pclk = ~pclk;

  spcs_top spcs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_global_irq_enable(glb), .txc_irq_ack(ack),
    .receive_irq(rx_irq), .transmit_done_irq(txc_irq), .buffer_empty_irq(be_irq),
    .rxd_in(rxd), .rxd_owned(rxd_own), .txd_out(txd), .txd_oe_n(txd_oe_n),
    .transfer_clock_pin_out(transfer_clock_pin), .transfer_clock_pin_oe_n(xck_oe_n));
  spcs_remote spcs_remote_inst (.pclk(pclk), .bit_cyc(bit_cyc), .txd(txd), .rxd(rxd),
    .got(got));

  // ------------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Poll status until transmit done shows, bounded
  task automatic wait_txc();
    rd = 32'h0;
    for (int i = 0; i < 300 && rd[6] !== 1'b1; i++) apb(1'b0, spcs_pkg::OFS_STATUS, 32'h0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, more than ten times the cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(spcs_pkg::OFS_STATUS, 32'h20);
    rdchk(spcs_pkg::OFS_FORMAT, 32'h06);
    rdchk(spcs_pkg::OFS_BAUDL, 32'h00);
    rdchk(8'h3C, 32'h00);
    chk(slv, 32'h1);
    apb(1'b1, spcs_pkg::OFS_BAUDH, 32'h00);
    apb(1'b1, spcs_pkg::OFS_BAUDL, 32'h00);
    apb(1'b1, spcs_pkg::OFS_CTRL, 32'h58);
    repeat (2) @(posedge pclk);
    chk({rxd_own, txd_oe_n}, 32'h2);
    chk({transfer_clock_pin, xck_oe_n}, 32'h1);
    apb(1'b1, spcs_pkg::OFS_DATA, 32'hA5);
    wait_txc();
    chk(rd, 32'h60);
    chk(got, 32'hA5);
    chk(txc_irq, 32'h0);
    glb <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(txc_irq, 32'h1);
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    rdchk(spcs_pkg::OFS_STATUS, 32'h20);
    // Double speed halves the bit time; error positions written as zero
    apb(1'b1, spcs_pkg::OFS_STATUS, 32'h02);
    bit_cyc <= 5'h08;
    apb(1'b1, spcs_pkg::OFS_DATA, 32'h5A);
    wait_txc();
    chk(got, 32'h5A);
    apb(1'b1, spcs_pkg::OFS_STATUS, 32'h42);
    rdchk(spcs_pkg::OFS_STATUS, 32'h22);
    spcs_remote_inst.send(8'h3C, 1'b1);
    repeat (4) @(posedge pclk);
    rdchk(spcs_pkg::OFS_STATUS, 32'hA2);
    rdchk(spcs_pkg::OFS_DATA, 32'h3C);
    rdchk(spcs_pkg::OFS_STATUS, 32'h22);
    spcs_remote_inst.send(8'h81, 1'b0);
    repeat (4) @(posedge pclk);
    rdchk(spcs_pkg::OFS_STATUS, 32'hB2);
    // Two queued, one waiting, then a further start bit overruns
    spcs_remote_inst.send(8'h11, 1'b1);
    @(posedge pclk);
    spcs_remote_inst.send(8'h22, 1'b1);
    @(posedge pclk);
    spcs_remote_inst.send(8'h33, 1'b1);
    repeat (4) @(posedge pclk);
    rdchk(spcs_pkg::OFS_STATUS, 32'hBA);
    rdchk(spcs_pkg::OFS_DATA, 32'h81);
    rdchk(spcs_pkg::OFS_STATUS, 32'hA2);
    rdchk(spcs_pkg::OFS_DATA, 32'h11);
    apb(1'b1, spcs_pkg::OFS_CTRL, 32'h08);
    rdchk(spcs_pkg::OFS_STATUS, 32'h22);
    chk(rxd_own, 32'h0);
    // Nine-bit frames under address filtering; ninth bits go first
    apb(1'b1, spcs_pkg::OFS_STATUS, 32'h03);
    apb(1'b1, spcs_pkg::OFS_CTRL, 32'hBD);
    apb(1'b1, spcs_pkg::OFS_DATA, 32'hC3);
    wait_txc();
    chk(got, 32'hC3);
    spcs_remote_inst.send(8'h55, 1'b0);
    repeat (16) @(posedge pclk);
    spcs_remote_inst.send(8'hA7, 1'b1);
    repeat (8) @(posedge pclk);
    chk({rx_irq, be_irq}, 32'h3);
    rdchk(spcs_pkg::OFS_CTRL, 32'hBF);
    rdchk(spcs_pkg::OFS_DATA, 32'hA7);
    // Disable with frames pending: pin held until both leave, third write lost
    apb(1'b1, spcs_pkg::OFS_STATUS, 32'h43);
    apb(1'b1, spcs_pkg::OFS_CTRL, 32'h08);
    apb(1'b1, spcs_pkg::OFS_DATA, 32'h11);
    apb(1'b1, spcs_pkg::OFS_DATA, 32'h22);
    apb(1'b1, spcs_pkg::OFS_DATA, 32'h33);
    rdchk(spcs_pkg::OFS_STATUS, 32'h03);
    apb(1'b1, spcs_pkg::OFS_CTRL, 32'h00);
    chk(txd_oe_n, 32'h0);
    wait_txc();
    chk(rd, 32'h63);
    chk(got, 32'h22);
    chk(txd_oe_n, 32'h1);
    // Divisor changed only with both directions idle
    apb(1'b1, spcs_pkg::OFS_BAUDL, 32'h03);
    repeat (12) @(posedge pclk);
    rdchk(spcs_pkg::OFS_BAUDL, 32'h03);
    report_and_stop();
  end
endmodule // spcs_top_tb
